// ### common/ffc_defines.vh
`ifndef FFC_DEFINES_VH
`define FFC_DEFINES_VH

// table sizes
`define FFC_N_RULES       8
`define FFC_RIDX_W        3
`define FFC_N_GROUPS      4
`define FFC_GIDX_W        2
`define FFC_N_SELS        5

// header window: eth | l3 (ipv6 size, ipv4 uses first 20) | l4 (tcp size)
`define FFC_ETH_BYTES     14
`define FFC_IP4_BYTES     20
`define FFC_IP6_BYTES     40
`define FFC_TCP_BYTES     20
`define FFC_UDP_BYTES     8
`define FFC_KEY_BYTES     74
`define FFC_KEY_W         592
`define FFC_L3_OFS        14
`define FFC_L4_OFS        54

// field positions inside the window (byte index)
`define FFC_IP4_FLAGS_BYTE 20
`define FFC_IP6_NH_BYTE    20

// selector type codes
`define FFC_SEL_ETH       8'h01
`define FFC_SEL_IP4       8'h02
`define FFC_SEL_IP6       8'h03
`define FFC_SEL_TCP       8'h04
`define FFC_SEL_UDP       8'h05

// action codes
`define FFC_ACT_DROP      8'h01
`define FFC_ACT_DIRECT    8'h02

// selector flag bits
`define FFC_SELF_PARTIAL  0

// partial masking support per type, bit n-1 for type n
`define FFC_PARTIAL_MAP   5'h1d

// advertised limits and capability values, loaded after reset
`define FFC_GROUPS_LIMIT  32'h0000_0004
`define FFC_SELS_LIMIT    32'h0000_0018
`define FFC_RULES_LIMIT   32'h0000_0008
`define FFC_RPG_LIMIT     32'h0000_0008
`define FFC_LAST_RPRIO    8'hff
`define FFC_SELS_PER_CLS  8'h03
`define FFC_ACT_COUNT     8'h02

`endif

// ### logic/ffc_rule_match.v
`include "ffc_defines.vh"

module ffc_rule_match (
  input  wire [`FFC_KEY_W-1:0] pkt_key,
  input  wire [7:0]            pkt_l3,
  input  wire [7:0]            pkt_l4,
  input  wire [`FFC_KEY_W-1:0] rule_key,
  input  wire [`FFC_KEY_W-1:0] rule_mask,
  input  wire [1:0]            rule_nsel,
  input  wire [7:0]            rule_l3,
  input  wire [7:0]            rule_l4,
  output wire                  hit
);
  wire [`FFC_KEY_W-1:0] sel_en;
  wire                  types_ok;

  // mask bytes past the last selector never take part
  genvar b;
  generate
    for (b = 0; b < `FFC_KEY_BYTES; b = b + 1) begin : g_en
      if (b < `FFC_L3_OFS) begin : g_eth
        assign sel_en[8*b+7:8*b] = 8'hff;
      end else if (b < `FFC_L4_OFS) begin : g_l3
        // ipv4 stops at the destination address; options never match
        assign sel_en[8*b+7:8*b] = (rule_nsel >= 2'd2 &&
          (rule_l3 == `FFC_SEL_IP6 || b < `FFC_L3_OFS + `FFC_IP4_BYTES)) ? 8'hff : 8'h00;
      end else begin : g_l4
        assign sel_en[8*b+7:8*b] = (rule_nsel == 2'd3 &&
          (rule_l4 == `FFC_SEL_TCP || b < `FFC_L4_OFS + `FFC_UDP_BYTES)) ? 8'hff : 8'h00;
      end
    end
  endgenerate

  assign types_ok = (rule_nsel < 2'd2 || rule_l3 == pkt_l3) &&
                    (rule_nsel < 2'd3 || rule_l4 == pkt_l4);

  // same selected bits from packet and key must be identical
  assign hit = types_ok && (((pkt_key ^ rule_key) & rule_mask & sel_en) == {`FFC_KEY_W{1'b0}});
endmodule

// ### logic/ffc_classifier.v
// What this block does
// - only packets that passed mac and vlan filtering are classified
// - a flow action skips rss steering; no action goes to rss if enabled
// - mac-filter discards skip both classification and rss steering
// - groups tried highest priority first, first matching group wins
// - every group priority is unique
// - a group holds zero up to the per-group rule limit
// - group and selector limits advertised as 32-bit little-endian values
// - total and per-group rule limits advertised as 32-bit values
// - highest rule priority advertised in 8 bits
// - selectors per classifier advertised in 8 bits
// - selector codes 1 eth 2 ipv4 3 ipv6 4 tcp 5 udp, rest reserved
// - without partial masking only the ipv4 flags field is forced to all ones or all zeros
// - selector flag bit 0 marks per-bit masking support
// - selector masks are network-order byte arrays with a length
// - selector entries sorted by type, unique, with a valid count
// - ipv6 next header compared against last extension header when present
// - action 1 drops, action 2 directs to a queue, others reserved
// - actions listed ascending, each once, after an 8-bit count
// - reserved capability fields read as zero
// - within a group rules tried highest rule priority first
// - rule matches when selected packet and key bits are identical
// - at most one flow action per packet
// - direct action places the packet on the rule's queue index
`include "ffc_defines.vh"

module ffc_classifier (
  input  wire                   mclk,
  input  wire                   reset,
  // packet side
  input  wire                   pkt_valid,
  input  wire                   pkt_mac_drop,
  input  wire                   pkt_filt_pass,
  input  wire [`FFC_KEY_W-1:0]  pkt_key,
  input  wire [7:0]             pkt_l3,
  input  wire [7:0]             pkt_l4,
  input  wire                   pkt_ip6_ext,
  input  wire [7:0]             pkt_ip6_last_nh,
  input  wire                   rss_en,
  output reg                    res_valid_q,
  output reg                    res_mac_drop_q,
  output reg                    res_ff_drop_q,
  output reg                    res_ff_direct_q,
  output reg  [15:0]            res_vq_q,
  output reg                    res_rss_q,
  // group configuration
  input  wire                   cfg_grp_we,
  input  wire [`FFC_GIDX_W-1:0] cfg_grp_idx,
  input  wire                   cfg_grp_valid,
  input  wire [15:0]            cfg_grp_prio,
  // rule configuration
  input  wire                   cfg_rule_we,
  input  wire [`FFC_RIDX_W-1:0] cfg_rule_idx,
  input  wire                   cfg_rule_valid,
  input  wire [`FFC_GIDX_W-1:0] cfg_rule_grp,
  input  wire [7:0]             cfg_rule_prio,
  input  wire [7:0]             cfg_rule_action,
  input  wire [15:0]            cfg_rule_vq,
  input  wire [1:0]             cfg_rule_nsel,
  input  wire [7:0]             cfg_rule_l3,
  input  wire [7:0]             cfg_rule_l4,
  input  wire [`FFC_KEY_W-1:0]  cfg_rule_key,
  input  wire [`FFC_KEY_W-1:0]  cfg_rule_mask,
  output reg                    cfg_ack_q,
  output reg                    cfg_err_q,
  // capabilities
  output reg  [31:0]            cap_groups_limit_q,
  output reg  [31:0]            cap_sels_limit_q,
  output reg  [31:0]            cap_rules_limit_q,
  output reg  [31:0]            cap_rpg_limit_q,
  output reg  [7:0]             cap_last_rprio_q,
  output reg  [7:0]             cap_sels_per_cls_q,
  output reg  [7:0]             cap_sel_count_q,
  output reg  [39:0]            cap_sel_types_q,
  output reg  [39:0]            cap_sel_flags_q,
  output reg  [39:0]            cap_sel_lens_q,
  output reg  [7:0]             cap_act_count_q,
  output reg  [15:0]            cap_act_list_q,
  output reg  [55:0]            cap_reserved_q
);

  // engine states
  localparam ST_IDLE = 2'b01;
  localparam ST_BUSY = 2'b10;

  // rule table
  reg                   rv_q    [0:`FFC_N_RULES-1];
  reg [`FFC_GIDX_W-1:0] rgrp_q  [0:`FFC_N_RULES-1];
  reg [7:0]             rprio_q [0:`FFC_N_RULES-1];
  reg [7:0]             ract_q  [0:`FFC_N_RULES-1];
  reg [15:0]            rvq_q   [0:`FFC_N_RULES-1];
  reg [1:0]             rnsel_q [0:`FFC_N_RULES-1];
  reg [7:0]             rl3_q   [0:`FFC_N_RULES-1];
  reg [7:0]             rl4_q   [0:`FFC_N_RULES-1];
  reg [`FFC_KEY_W-1:0]  rkey_q  [0:`FFC_N_RULES-1];
  reg [`FFC_KEY_W-1:0]  rmask_q [0:`FFC_N_RULES-1];

  // group table
  reg                   gv_q    [0:`FFC_N_GROUPS-1];
  reg [15:0]            gprio_q [0:`FFC_N_GROUPS-1];

  reg [1:0]             state_q;
  reg [1:0]             state_d;

  wire [`FFC_N_RULES-1:0] hit;
  wire [`FFC_KEY_W-1:0]   pkt_key_eff;

  // is a selector code a defined one
  function sel_code_ok;
    input [7:0] code;
    begin
      sel_code_ok = (code >= `FFC_SEL_ETH) && (code <= `FFC_SEL_UDP);
    end
  endfunction

  // partial masking support for a type
  function sel_partial;
    input [7:0] code;
    reg   [4:0] map;
    begin
      map = `FFC_PARTIAL_MAP;
      sel_partial = sel_code_ok(code) ? map[code[2:0]-3'd1] : 1'b0;
    end
  endfunction

  // ipv6 next header comes from the last extension header when present
  assign pkt_key_eff = (pkt_l3 == `FFC_SEL_IP6 && pkt_ip6_ext) ?
    {pkt_key[`FFC_KEY_W-1:8*`FFC_IP6_NH_BYTE+8], pkt_ip6_last_nh,
     pkt_key[8*`FFC_IP6_NH_BYTE-1:0]} : pkt_key;

  genvar r;
  generate
    for (r = 0; r < `FFC_N_RULES; r = r + 1) begin : g_match
      ffc_rule_match u_match (
        .pkt_key   (pkt_key_eff),
        .pkt_l3    (pkt_l3),
        .pkt_l4    (pkt_l4),
        .rule_key  (rkey_q[r]),
        .rule_mask (rmask_q[r]),
        .rule_nsel (rnsel_q[r]),
        .rule_l3   (rl3_q[r]),
        .rule_l4   (rl4_q[r]),
        .hit       (hit[r])
      );
    end
  endgenerate

  // pick the winner: group priority above rule priority
  reg                   win_any;
  reg [`FFC_RIDX_W-1:0] win_idx;
  reg [23:0]            win_score;
  reg [23:0]            cand;
  integer               i;
  always @* begin
    win_any   = 1'b0;
    win_idx   = {`FFC_RIDX_W{1'b0}};
    win_score = 24'h00_0000;
    cand      = 24'h00_0000;
    for (i = 0; i < `FFC_N_RULES; i = i + 1) begin
      cand = {gprio_q[rgrp_q[i]], rprio_q[i]};
      // a rule of a missing group counts as absent, so empty groups fall through
      if (rv_q[i] && gv_q[rgrp_q[i]] && hit[i] &&
          (!win_any || cand > win_score)) begin
        win_any   = 1'b1;
        win_idx   = i[`FFC_RIDX_W-1:0];
        win_score = cand;
      end
    end
  end

  // configuration checks
  reg [7:0] grp_fill;
  reg       prio_clash;
  reg       rule_bad;
  reg       grp_bad;
  integer   j;
  always @* begin
    grp_fill   = 8'h00;
    prio_clash = 1'b0;
    for (j = 0; j < `FFC_N_RULES; j = j + 1) begin
      // the slot being rewritten does not count against its own group
      if (rv_q[j] && rgrp_q[j] == cfg_rule_grp && j != cfg_rule_idx)
        grp_fill = grp_fill + 8'h01;
    end
    for (j = 0; j < `FFC_N_GROUPS; j = j + 1) begin
      if (gv_q[j] && gprio_q[j] == cfg_grp_prio && j != cfg_grp_idx)
        prio_clash = 1'b1;
    end
    grp_bad  = cfg_grp_valid && prio_clash;
    rule_bad = cfg_rule_valid && (
      !gv_q[cfg_rule_grp] ||
      {24'h00_0000, grp_fill} >= `FFC_RPG_LIMIT ||
      cfg_rule_prio > `FFC_LAST_RPRIO ||
      (cfg_rule_action != `FFC_ACT_DROP && cfg_rule_action != `FFC_ACT_DIRECT) ||
      cfg_rule_nsel == 2'd0 ||
      (cfg_rule_nsel >= 2'd2 && cfg_rule_l3 != `FFC_SEL_IP4 && cfg_rule_l3 != `FFC_SEL_IP6) ||
      (cfg_rule_nsel == 2'd3 && cfg_rule_l4 != `FFC_SEL_TCP && cfg_rule_l4 != `FFC_SEL_UDP));
  end

  // ipv4 flags widen to the whole field when that type has no partial masking;
  // tcp control bits are left bit by bit on purpose
  reg [`FFC_KEY_W-1:0] mask_norm;
  reg [7:0]            fl;
  always @* begin
    mask_norm = cfg_rule_mask;
    fl        = cfg_rule_mask[8*`FFC_IP4_FLAGS_BYTE+7 -: 8];
    if (cfg_rule_l3 == `FFC_SEL_IP4 && !sel_partial(`FFC_SEL_IP4)) begin
      fl[7:5] = (|fl[7:5]) ? 3'h7 : 3'h0;
      mask_norm[8*`FFC_IP4_FLAGS_BYTE+7 -: 8] = fl;
    end
  end

  // a single write is taken per cycle; rule writes win over group writes
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg_ack_q <= 1'b0;
      cfg_err_q <= 1'b0;
    end else begin
      cfg_ack_q <= cfg_rule_we || cfg_grp_we;
      cfg_err_q <= cfg_rule_we ? rule_bad : (cfg_grp_we && grp_bad);
    end
  end

  integer k;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (k = 0; k < `FFC_N_RULES; k = k + 1) begin
        rv_q[k]    <= 1'b0;
        rgrp_q[k]  <= {`FFC_GIDX_W{1'b0}};
        rprio_q[k] <= 8'h00;
        ract_q[k]  <= 8'h00;
        rvq_q[k]   <= 16'h0000;
        rnsel_q[k] <= 2'h0;
        rl3_q[k]   <= 8'h00;
        rl4_q[k]   <= 8'h00;
        rkey_q[k]  <= {`FFC_KEY_W{1'b0}};
        rmask_q[k] <= {`FFC_KEY_W{1'b0}};
      end
    end else if (cfg_rule_we && !rule_bad) begin
      rv_q[cfg_rule_idx]    <= cfg_rule_valid;
      rgrp_q[cfg_rule_idx]  <= cfg_rule_grp;
      rprio_q[cfg_rule_idx] <= cfg_rule_prio;
      ract_q[cfg_rule_idx]  <= cfg_rule_action;
      rvq_q[cfg_rule_idx]   <= cfg_rule_vq;
      rnsel_q[cfg_rule_idx] <= cfg_rule_nsel;
      rl3_q[cfg_rule_idx]   <= cfg_rule_l3;
      rl4_q[cfg_rule_idx]   <= cfg_rule_l4;
      rkey_q[cfg_rule_idx]  <= cfg_rule_key;
      rmask_q[cfg_rule_idx] <= mask_norm;
    end
  end

  integer g;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (g = 0; g < `FFC_N_GROUPS; g = g + 1) begin
        gv_q[g]    <= 1'b0;
        gprio_q[g] <= 16'h0000;
      end
    end else if (cfg_grp_we && !cfg_rule_we && !grp_bad) begin
      gv_q[cfg_grp_idx]    <= cfg_grp_valid;
      gprio_q[cfg_grp_idx] <= cfg_grp_prio;
    end
  end

  // busy marks the cycle after a packet, while its result stands on the outputs
  always @* begin
    case (state_q)
      ST_IDLE: state_d = pkt_valid ? ST_BUSY : ST_IDLE;
      ST_BUSY: state_d = pkt_valid ? ST_BUSY : ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // one result per packet, one cycle later; packets may follow back to back
  wire classify = pkt_valid && !pkt_mac_drop && pkt_filt_pass;
  wire act      = classify && win_any;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q         <= ST_IDLE;
      res_valid_q     <= 1'b0;
      res_mac_drop_q  <= 1'b0;
      res_ff_drop_q   <= 1'b0;
      res_ff_direct_q <= 1'b0;
      res_vq_q        <= 16'h0000;
      res_rss_q       <= 1'b0;
    end else begin
      state_q         <= state_d;
      res_valid_q     <= pkt_valid;
      res_mac_drop_q  <= pkt_valid && pkt_mac_drop;
      // only the single winner's action is applied
      res_ff_drop_q   <= act && ract_q[win_idx] == `FFC_ACT_DROP;
      res_ff_direct_q <= act && ract_q[win_idx] == `FFC_ACT_DIRECT;
      res_vq_q        <= (act && ract_q[win_idx] == `FFC_ACT_DIRECT) ?
                         rvq_q[win_idx] : 16'h0000;
      res_rss_q       <= classify && !win_any && rss_en;
    end
  end

  // capability image, held constant after reset
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      cap_groups_limit_q <= 32'h0000_0000;
      cap_sels_limit_q   <= 32'h0000_0000;
      cap_rules_limit_q  <= 32'h0000_0000;
      cap_rpg_limit_q    <= 32'h0000_0000;
      cap_last_rprio_q   <= 8'h00;
      cap_sels_per_cls_q <= 8'h00;
      cap_sel_count_q    <= 8'h00;
      cap_sel_types_q    <= 40'h00_0000_0000;
      cap_sel_flags_q    <= 40'h00_0000_0000;
      cap_sel_lens_q     <= 40'h00_0000_0000;
      cap_act_count_q    <= 8'h00;
      cap_act_list_q     <= 16'h0000;
      cap_reserved_q     <= 56'h00_0000_0000_0000;
    end else begin
      // byte 0 in bits 7:0, the little-endian image
      cap_groups_limit_q <= `FFC_GROUPS_LIMIT;
      cap_sels_limit_q   <= `FFC_SELS_LIMIT;
      cap_rules_limit_q  <= `FFC_RULES_LIMIT;
      cap_rpg_limit_q    <= `FFC_RPG_LIMIT;
      cap_last_rprio_q   <= `FFC_LAST_RPRIO;
      cap_sels_per_cls_q <= `FFC_SELS_PER_CLS;
      cap_sel_count_q    <= 8'h05;
      // entry 0 in the low byte, ascending type order
      cap_sel_types_q    <= {`FFC_SEL_UDP, `FFC_SEL_TCP, `FFC_SEL_IP6,
                             `FFC_SEL_IP4, `FFC_SEL_ETH};
      cap_sel_flags_q    <= {7'h00, sel_partial(`FFC_SEL_UDP),
                             7'h00, sel_partial(`FFC_SEL_TCP),
                             7'h00, sel_partial(`FFC_SEL_IP6),
                             7'h00, sel_partial(`FFC_SEL_IP4),
                             7'h00, sel_partial(`FFC_SEL_ETH)};
      cap_sel_lens_q     <= {8'd`FFC_UDP_BYTES, 8'd`FFC_TCP_BYTES, 8'd`FFC_IP6_BYTES,
                             8'd`FFC_IP4_BYTES, 8'd`FFC_ETH_BYTES};
      cap_act_count_q    <= `FFC_ACT_COUNT;
      cap_act_list_q     <= {`FFC_ACT_DIRECT, `FFC_ACT_DROP};
      cap_reserved_q     <= 56'h00_0000_0000_0000;
    end
  end

endmodule

// ### verif/ffc_classifier_asserts.sv
module ffc_classifier_asserts (
  input logic        mclk,
  input logic        reset,
  input logic        pkt_valid,
  input logic        pkt_mac_drop,
  input logic        pkt_filt_pass,
  input logic        rss_en,
  input logic        res_valid_q,
  input logic        res_mac_drop_q,
  input logic        res_ff_drop_q,
  input logic        res_ff_direct_q,
  input logic [15:0] res_vq_q,
  input logic        res_rss_q,
  input logic        cfg_grp_we,
  input logic        cfg_rule_we,
  input logic        cfg_rule_valid,
  input logic [7:0]  cfg_rule_action,
  input logic [1:0]  cfg_rule_nsel,
  input logic        cfg_ack_q,
  input logic        cfg_err_q,
  input logic [39:0] cap_sel_types_q,
  input logic [15:0] cap_act_list_q,
  input logic [55:0] cap_reserved_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);
  sequence s_pkt_ok;
    pkt_valid && pkt_filt_pass && !pkt_mac_drop;
  endsequence
  sequence s_no_flow;
    !res_ff_drop_q && !res_ff_direct_q;
  endsequence
  sequence s_bad_rule;
    cfg_rule_we && cfg_rule_valid && (cfg_rule_action == 8'h00 || cfg_rule_action > 8'h02 || cfg_rule_nsel == 2'h0);
  endsequence
  chk_pkt_answer: assert property (pkt_valid |=> res_valid_q && res_valid_q == $past(pkt_valid))
    else $error("result not one cycle after packet");
  chk_unfiltered_idle: assert property (pkt_valid && !pkt_filt_pass && !pkt_mac_drop |=> s_no_flow and !res_rss_q)
    else $error("unfiltered packet was classified");
  chk_mac_drop_bypass: assert property (pkt_valid && pkt_mac_drop |=> (res_mac_drop_q && !res_rss_q) and s_no_flow)
    else $error("mac discard reached classifier or steering");
  chk_action_no_rss: assert property (res_ff_drop_q || res_ff_direct_q |-> !res_rss_q)
    else $error("steering applied after flow action");
  chk_rss_follows_en: assert property (s_pkt_ok ##1 s_no_flow |-> res_rss_q == $past(rss_en))
    else $error("steering does not follow enable");
  chk_one_action: assert property (!(res_ff_drop_q && res_ff_direct_q))
    else $error("two flow actions on one packet");
  chk_vq_idle_zero: assert property (!res_ff_direct_q |-> res_vq_q == 16'h0000)
    else $error("queue index shown without direct action");
  chk_cfg_ack: assert property ((cfg_grp_we || cfg_rule_we) |=> cfg_ack_q)
    else $error("config write not acknowledged");
  chk_bad_rule_err: assert property (s_bad_rule |=> cfg_ack_q && cfg_err_q)
    else $error("illegal rule accepted");
  chk_err_with_ack: assert property (cfg_err_q |-> cfg_ack_q)
    else $error("error without acknowledge");
  chk_cap_values: assert property (!$past(reset) |-> cap_sel_types_q == 40'h0504030201 &&
    cap_act_list_q == 16'h0201 && cap_reserved_q == 56'h0)
    else $error("capability value wrong");
endmodule

bind ffc_classifier ffc_classifier_asserts u_ffc_classifier_asserts (
  .mclk, .reset, .pkt_valid, .pkt_mac_drop, .pkt_filt_pass, .rss_en, .res_valid_q, .res_mac_drop_q,
  .res_ff_drop_q, .res_ff_direct_q, .res_vq_q, .res_rss_q, .cfg_grp_we, .cfg_rule_we, .cfg_rule_valid,
  .cfg_rule_action, .cfg_rule_nsel, .cfg_ack_q, .cfg_err_q, .cap_sel_types_q, .cap_act_list_q, .cap_reserved_q);

// ### verif/ffc_rxq_model.sv
module ffc_rxq_model (
  input  logic        mclk,
  input  logic        reset,
  input  logic        res_valid_q,
  input  logic        res_mac_drop_q,
  input  logic        res_ff_drop_q,
  input  logic        res_ff_direct_q,
  input  logic [15:0] res_vq_q,
  input  logic        res_rss_q,
  output logic [7:0]  rx_count_q,
  output logic [19:0] rx_last_q
);
  timeunit 1ns;
  timeprecision 100ps;
  // queue side never stalls, so every answer is taken in the cycle it stands
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_count_q <= 8'h00;
      rx_last_q  <= 20'h00000;
    end else if (res_valid_q) begin
      rx_count_q <= rx_count_q + 8'h01;
      rx_last_q  <= {res_mac_drop_q, res_ff_drop_q, res_ff_direct_q, res_rss_q, res_vq_q};
    end
  end
endmodule

// ### verif/flow_filter_classifier_tb_top.sv
`include "ffc_defines.vh"
module flow_filter_classifier_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                  mclk = 1'h0, reset = 1'h1, rss_en = 1'h1, pkt_ip6_ext = 1'h0;
  logic                  pkt_valid = 1'h0, pkt_mac_drop = 1'h0, pkt_filt_pass = 1'h0;
  logic [`FFC_KEY_W-1:0] pkt_key = '0, cfg_rule_key = '0, cfg_rule_mask = '0;
  logic [7:0]            pkt_l3 = 8'h02, pkt_l4 = 8'h04, pkt_ip6_last_nh = 8'h00;
  logic                  cfg_grp_we = 1'h0, cfg_grp_valid = 1'h0, cfg_rule_we = 1'h0, cfg_rule_valid = 1'h0;
  logic [1:0]            cfg_grp_idx = 2'h0, cfg_rule_grp = 2'h0, cfg_rule_nsel = 2'h0;
  logic [2:0]            cfg_rule_idx = 3'h0;
  logic [15:0]           cfg_grp_prio = 16'h0, cfg_rule_vq = 16'h0, res_vq_q, cap_act_list_q;
  logic [7:0]            cfg_rule_prio = 8'h0, cfg_rule_action = 8'h0, cfg_rule_l3 = 8'h0, cfg_rule_l4 = 8'h0;
  logic                  res_valid_q, res_mac_drop_q, res_ff_drop_q, res_ff_direct_q, res_rss_q, cfg_ack_q, cfg_err_q;
  logic [31:0]           cap_groups_limit_q, cap_sels_limit_q, cap_rules_limit_q, cap_rpg_limit_q;
  logic [7:0]            cap_last_rprio_q, cap_sels_per_cls_q, cap_sel_count_q, cap_act_count_q, rx_count_q;
  logic [39:0]           cap_sel_types_q, cap_sel_flags_q, cap_sel_lens_q;
  logic [55:0]           cap_reserved_q;
  logic [19:0]           rx_last_q;
  int                    err_count = 0, checks_done = 0;

  always #12.5 mclk = ~mclk;

  ffc_classifier u_ffc_classifier (
    .mclk, .reset, .pkt_valid, .pkt_mac_drop, .pkt_filt_pass, .pkt_key, .pkt_l3, .pkt_l4, .pkt_ip6_ext,
    .pkt_ip6_last_nh, .rss_en, .res_valid_q, .res_mac_drop_q, .res_ff_drop_q, .res_ff_direct_q, .res_vq_q,
    .res_rss_q, .cfg_grp_we, .cfg_grp_idx, .cfg_grp_valid, .cfg_grp_prio, .cfg_rule_we, .cfg_rule_idx,
    .cfg_rule_valid, .cfg_rule_grp, .cfg_rule_prio, .cfg_rule_action, .cfg_rule_vq, .cfg_rule_nsel,
    .cfg_rule_l3, .cfg_rule_l4, .cfg_rule_key, .cfg_rule_mask, .cfg_ack_q, .cfg_err_q, .cap_groups_limit_q,
    .cap_sels_limit_q, .cap_rules_limit_q, .cap_rpg_limit_q, .cap_last_rprio_q, .cap_sels_per_cls_q,
    .cap_sel_count_q, .cap_sel_types_q, .cap_sel_flags_q, .cap_sel_lens_q, .cap_act_count_q,
    .cap_act_list_q, .cap_reserved_q);

  ffc_rxq_model u_ffc_rxq_model (
    .mclk, .reset, .res_valid_q, .res_mac_drop_q, .res_ff_drop_q, .res_ff_direct_q, .res_vq_q, .res_rss_q,
    .rx_count_q, .rx_last_q);

  task automatic cmp_val(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // group write: ack always comes, err only when refused
  task automatic grp_wr(input logic [1:0] idx, input logic [15:0] prio, input logic exp_err);
    @(posedge mclk);
    #2;
    {cfg_grp_we, cfg_grp_idx, cfg_grp_valid, cfg_grp_prio} = {1'h1, idx, 1'h1, prio};
    @(posedge mclk);
    #2;
    cfg_grp_we = 1'h0;
    cmp_val({cfg_ack_q, cfg_err_q}, {1'h1, exp_err});
  endtask

  // rule write; key and mask reach window bytes 0-47 only
  task automatic rule_wr(input logic [2:0] idx, input logic [1:0] grp, input logic [7:0] prio, input logic [7:0] act,
                         input logic [15:0] vq, input logic [1:0] nsel, input logic [7:0] l3, input logic [383:0] k,
                         input logic [383:0] m, input logic exp_err);
    @(posedge mclk);
    #2;
    {cfg_rule_we, cfg_rule_valid, cfg_rule_idx, cfg_rule_grp, cfg_rule_prio} = {2'h3, idx, grp, prio};
    {cfg_rule_action, cfg_rule_vq, cfg_rule_nsel, cfg_rule_l3, cfg_rule_l4} = {act, vq, nsel, l3, 8'h04};
    cfg_rule_key = {208'h0, k};
    cfg_rule_mask = {208'h0, m};
    @(posedge mclk);
    #2;
    cfg_rule_we = 1'h0;
    cmp_val({cfg_ack_q, cfg_err_q}, {1'h1, exp_err});
  endtask

  // flags are {mac drop, flow drop, direct, rss}
  task automatic send(input logic [383:0] k, input logic md, input logic fp, input logic [3:0] fl, input logic [15:0] vq);
    @(posedge mclk);
    #2;
    {pkt_valid, pkt_mac_drop, pkt_filt_pass} = {1'h1, md, fp};
    pkt_key = {208'h0, k};
    @(posedge mclk);
    #2;
    pkt_valid = 1'h0;
    @(posedge mclk);
    #2;
    cmp_val(rx_last_q, {fl, vq});
  endtask

  initial begin
    #50us;
    err_count++;
    end_of_test;
  end

  initial begin
    repeat (6) @(posedge mclk);
    #2;
    reset = 1'h0;
    repeat (2) @(posedge mclk);
    #2;
    cmp_val({cap_groups_limit_q, cap_sels_limit_q}, {`FFC_GROUPS_LIMIT, `FFC_SELS_LIMIT});
    cmp_val({cap_rules_limit_q, cap_rpg_limit_q}, {`FFC_RULES_LIMIT, `FFC_RPG_LIMIT});
    cmp_val(cap_last_rprio_q, `FFC_LAST_RPRIO);
    cmp_val(cap_sels_per_cls_q, `FFC_SELS_PER_CLS);
    cmp_val({cap_sel_count_q, cap_sel_types_q}, 48'h05_0504030201);
    cmp_val(cap_sel_flags_q, 40'h0101010001);
    cmp_val(cap_sel_lens_q, 40'h081428140e);
    cmp_val({cap_act_count_q, cap_act_list_q}, 24'h020201);
    cmp_val(cap_reserved_q, 56'h0);
    grp_wr(2'h0, 16'h0004, 1'h0);
    grp_wr(2'h1, 16'h0005, 1'h0);
    grp_wr(2'h2, 16'h0004, 1'h1);
    grp_wr(2'h2, 16'h0009, 1'h0);
    rule_wr(3'h3, 2'h0, 8'h01, 8'h00, 16'h0, 2'h1, 8'h00, 16'h0, 16'h0, 1'h1);
    rule_wr(3'h3, 2'h0, 8'h01, 8'h03, 16'h0, 2'h1, 8'h00, 16'h0, 16'h0, 1'h1);
    rule_wr(3'h3, 2'h0, 8'h01, 8'h01, 16'h0, 2'h0, 8'h00, 16'h0, 16'h0, 1'h1);
    rule_wr(3'h3, 2'h0, 8'h01, 8'h01, 16'h0, 2'h2, 8'h06, 16'h0, 16'h0, 1'h1);
    rule_wr(3'h0, 2'h0, 8'h01, 8'h02, 16'h0007, 2'h1, 8'h00, 16'h00aa, 16'h00ff, 1'h0);
    rule_wr(3'h1, 2'h1, 8'h01, 8'h01, 16'h0, 2'h1, 8'h00, 16'h11aa, 16'hffff, 1'h0);
    send(16'h11aa, 1'h0, 1'h1, 4'b0100, 16'h0);
    send(16'h22aa, 1'h0, 1'h1, 4'b0010, 16'h0007);
    send(16'h22bb, 1'h0, 1'h1, 4'b0001, 16'h0);
    rss_en = 1'h0;
    send(16'h22bb, 1'h0, 1'h1, 4'b0000, 16'h0);
    rss_en = 1'h1;
    send(16'h11aa, 1'h1, 1'h1, 4'b1000, 16'h0);
    send(16'h11aa, 1'h0, 1'h0, 4'b0000, 16'h0);
    rule_wr(3'h2, 2'h0, 8'h09, 8'h02, 16'h0003, 2'h1, 8'h00, 16'h00aa, 16'h00ff, 1'h0);
    send(16'h33aa, 1'h0, 1'h1, 4'b0010, 16'h0003);
    cmp_val(rx_count_q, 8'h07);
    rule_wr(3'h4, 2'h2, 8'h01, 8'h02, 16'h0005, 2'h2, 8'h03, 384'h11 << 160, 384'hff << 160, 1'h0);
    rule_wr(3'h5, 2'h1, 8'h02, 8'h01, 16'h0, 2'h2, 8'h02, 384'h0, (384'h20 << 160) | (384'hff << 272), 1'h0);
    send(384'hff << 272, 1'h0, 1'h1, 4'b0100, 16'h0);
    send(384'h40 << 160, 1'h0, 1'h1, 4'b0001, 16'h0);
    {pkt_l3, pkt_ip6_ext, pkt_ip6_last_nh} = {8'h03, 1'h1, 8'h11};
    send(384'h06 << 160, 1'h0, 1'h1, 4'b0010, 16'h0005);
    pkt_ip6_ext = 1'h0;
    send(384'h06 << 160, 1'h0, 1'h1, 4'b0001, 16'h0);
    end_of_test;
  end
endmodule
